/* File: verilog/hsq_pkg.sv */
// Purpose: Shared constants and types for the two-stage heat sequencer
// Assumes: clk_sys at 10 MHz; timers specified in whole seconds
// Notes:   Cycle counts are derived from the second figures below

package hsq_pkg;

   // System clock rate
   localparam int unsigned CLK_HZ      = 10_000_000;

   // Sequence times in seconds
   localparam int unsigned WARMUP_S    = 17;
   localparam int unsigned BLOWER_ON_S = 30;
   localparam int unsigned POSTPURGE_S = 15;
   localparam int unsigned FLAME_TMO_S = 4;
   localparam int unsigned OFFDLY0_S   = 60;
   localparam int unsigned OFFDLY1_S   = 90;
   localparam int unsigned OFFDLY2_S   = 120;
   localparam int unsigned OFFDLY3_S   = 180;

   // Same times in clock cycles
   localparam logic [31:0] WARMUP_CYC    = 32'(WARMUP_S * CLK_HZ);
   localparam logic [31:0] BLOWER_ON_CYC = 32'(BLOWER_ON_S * CLK_HZ);
   localparam logic [31:0] POSTPURGE_CYC = 32'(POSTPURGE_S * CLK_HZ);
   localparam logic [31:0] FLAME_TMO_CYC = 32'(FLAME_TMO_S * CLK_HZ);
   localparam logic [31:0] OFFDLY0_CYC   = 32'(OFFDLY0_S * CLK_HZ);
   localparam logic [31:0] OFFDLY1_CYC   = 32'(OFFDLY1_S * CLK_HZ);
   localparam logic [31:0] OFFDLY2_CYC   = 32'(OFFDLY2_S * CLK_HZ);
   localparam logic [31:0] OFFDLY3_CYC   = 32'(OFFDLY3_S * CLK_HZ);

   // Flame current thresholds in tenths of a microamp
   localparam logic [7:0]  FLAME_MIN_X10  = 8'h01;
   localparam logic [7:0]  FLAME_WEAK_X10 = 8'h0f;

   // Fault codes, shown as red flash counts
   localparam logic [3:0]  FC_NONE       = 4'h0;
   localparam logic [3:0]  FC_PS_STUCK   = 4'h2;
   localparam logic [3:0]  FC_LIMIT      = 4'h4;
   localparam logic [3:0]  FC_NO_FLAME   = 4'h5;
   localparam logic [3:0]  FC_FLAME_LOST = 4'h6;

   // Reset values
   localparam logic [31:0] TMR_RST  = 32'h0;
   localparam logic [7:0]  PWM_RST  = 8'h0;

   // Burner sequence states
   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_OPEN_CHK  = 3'b001,
      ST_PREPURGE  = 3'b010,
      ST_WARMUP    = 3'b011,
      ST_TRIAL     = 3'b100,
      ST_RUN       = 3'b101,
      ST_POSTPURGE = 3'b110,
      ST_LOCKOUT   = 3'b111
   } hsq_state_t;

   // Circulating blower states
   typedef enum logic [1:0] {
      BL_OFF   = 2'b00,
      BL_WAIT  = 2'b01,
      BL_ON    = 2'b10,
      BL_DELAY = 2'b11
   } hsq_blw_t;

endpackage : hsq_pkg

/* File: verilog/hsq_pwm.sv */
// Purpose: Free-running duty-cycle generator for the blower speed signal
// Assumes: Duty is a fraction of 256 clock periods
// Notes:   Output is forced low from the clock after the enable goes low

`timescale 1ns/10ps

module hsq_pwm
   import hsq_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Control
   input  wire logic       en,
   input  wire logic [7:0] duty,
   // Output
   output logic            pwm
);

   logic [7:0] cnt_q;
   logic       pwm_q;
   wire        pwm_d = en && (cnt_q < duty);

   // Period counter and registered output, so the motor never sees glitches
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_q <= PWM_RST;
         pwm_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 8'h1;
         pwm_q <= pwm_d;
      end
   end

   assign pwm = pwm_q;

endmodule : hsq_pwm

/* File: verilog/hsq_sequencer.sv */
// Purpose: Two-stage furnace heat sequencer with blower control
// Assumes: All inputs synchronous to clk_sys; flame current pre-digitised
// Notes:   Long timers are parameters so simulation can shorten them
// Notes on behaviour
// - Standby drives limit test, expects return
// - Stage one call alone starts heating
// - Closed pressure switch at start: fault two
// - Pre-purge on high inducer plus humidifier
// - Wait for both pressure switches closed
// - Ignitor warms seventeen seconds before valve
// - Then main valve opens at high fire
// - Flame must prove within a short window
// - Run needs 0.1 uA; weak below 1.5
// - Stage one: inducer drops to low speed
// - Blower starts thirty seconds after flame proof
// - Blower enable asserted every blower run
// - PWM duty encodes commanded airflow
// - Air cleaner follows the blower
// - Both calls together mean stage two
// - Low tap stage one, high tap stage two
// - Call end: valve off, purge, then release
// - Blower runs through selectable off delay
// - Master may force calls and settings

`timescale 1ns/10ps

module hsq_sequencer
   import hsq_pkg::*;
#(
   parameter logic [31:0] P_WARMUP_CYC    = WARMUP_CYC,
   parameter logic [31:0] P_BLOWER_ON_CYC = BLOWER_ON_CYC,
   parameter logic [31:0] P_POSTPURGE_CYC = POSTPURGE_CYC,
   parameter logic [31:0] P_FLAME_TMO_CYC = FLAME_TMO_CYC,
   parameter logic [31:0] P_OFFDLY0_CYC   = OFFDLY0_CYC,
   parameter logic [31:0] P_OFFDLY1_CYC   = OFFDLY1_CYC,
   parameter logic [31:0] P_OFFDLY2_CYC   = OFFDLY2_CYC,
   parameter logic [31:0] P_OFFDLY3_CYC   = OFFDLY3_CYC
)
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Thermostat calls
   input  wire logic       heat_stage1_call,
   input  wire logic       heat_stage2_call,
   input  wire logic       cool_call,
   input  wire logic       fan_call,
   // Safety and flame sense
   input  wire logic       ps_low_closed,
   input  wire logic       ps_high_closed,
   input  wire logic       limit_return,
   input  wire logic [7:0] flame_ua_x10,
   // Board jumpers
   input  wire logic [7:0] jumper_airflow,
   input  wire logic [1:0] jumper_off_delay,
   // Communicating master
   input  wire logic       master_present,
   input  wire logic       master_force_heat1,
   input  wire logic       master_force_heat2,
   input  wire logic [7:0] master_airflow,
   input  wire logic [1:0] master_off_delay,
   // Burner outputs
   output logic            limit_test_out,
   output logic            inducer_high,
   output logic            inducer_low,
   output logic            humidifier_out,
   output logic            ignitor_out,
   output logic            valve_main,
   output logic            valve_high_fire,
   // Blower outputs
   output logic            blower_enable,
   output logic            blower_pwm,
   output logic            blower_low_heat_tap,
   output logic            blower_high_heat_tap,
   output logic            air_cleaner_out,
   // Status
   output logic            weak_flame,
   output logic [3:0]      fault_code
);

   hsq_state_t  state_q, state_d;
   hsq_blw_t    blw_q, blw_d;
   logic [31:0] tmr_q, tmr_d;
   logic [31:0] btmr_q, btmr_d;
   logic [3:0]  fault_q, fault_d;
   logic        limit_test_q, limit_fault_q;
   logic        stage2_q, weak_q;
   logic        ind_hi_q, ind_lo_q, hum_q, ign_q;
   logic        vmain_q, vhigh_q, blw_on_q;

   // Master overrides jumpers and may force calls
   wire         call1   = heat_stage1_call | (master_present & master_force_heat1);
   wire         call2   = heat_stage2_call | (master_present & master_force_heat2);
   wire         heat_req = call1;
   wire         stage2_req = call1 & call2;
   wire [7:0]   airflow = master_present ? master_airflow : jumper_airflow;
   wire [1:0]   dly_sel = master_present ? master_off_delay : jumper_off_delay;
   wire         any_call = call1 | call2 | cool_call | fan_call;

   // Flame thresholds and pressure switch terms
   wire         flame_ok = flame_ua_x10 >= FLAME_MIN_X10;
   wire         flame_weak = flame_ua_x10 < FLAME_WEAK_X10;
   wire         ps_any = ps_low_closed | ps_high_closed;
   wire         ps_both = ps_low_closed & ps_high_closed;

   // Timer expiry terms
   wire         warm_done = tmr_q == P_WARMUP_CYC - 32'h1;
   wire         tmo_done  = tmr_q == P_FLAME_TMO_CYC - 32'h1;
   wire         purge_done = tmr_q == P_POSTPURGE_CYC - 32'h1;
   wire         bon_done  = btmr_q == P_BLOWER_ON_CYC - 32'h1;
   wire [31:0]  offdly_cyc = (dly_sel == 2'h0) ? P_OFFDLY0_CYC :
                             (dly_sel == 2'h1) ? P_OFFDLY1_CYC :
                             (dly_sel == 2'h2) ? P_OFFDLY2_CYC : P_OFFDLY3_CYC;
   wire         boff_done = btmr_q == offdly_cyc - 32'h1;

   // Burner sequence; a call dropped from pre-purge through run goes straight to post-purge
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
            if (heat_req && !limit_fault_q)
               state_d = ST_OPEN_CHK;
         ST_OPEN_CHK:
            if (!heat_req)
               state_d = ST_IDLE;
            else if (ps_any)
               state_d = ST_LOCKOUT;
            else
               state_d = ST_PREPURGE;
         ST_PREPURGE:
            if (!heat_req)
               state_d = ST_POSTPURGE;
            else if (ps_both)
               state_d = ST_WARMUP;
         ST_WARMUP:
            if (!heat_req)
               state_d = ST_POSTPURGE;
            else if (warm_done)
               state_d = ST_TRIAL;
         ST_TRIAL:
            if (!heat_req)
               state_d = ST_POSTPURGE;
            else if (flame_ok)
               state_d = ST_RUN;
            else if (tmo_done)
               state_d = ST_LOCKOUT;
         ST_RUN:
            if (!heat_req || !flame_ok)
               state_d = ST_POSTPURGE;
         ST_POSTPURGE:
            if (purge_done)
               state_d = ST_IDLE;
         ST_LOCKOUT:
            if (!heat_req)
               state_d = ST_IDLE;
      endcase
   end

   // Phase timer restarts on every state change
   assign tmr_d = (state_d != state_q) ? TMR_RST : tmr_q + 32'h1;

   // Fault code: latched by cause, cleared when a new cycle begins
   always_comb
   begin
      fault_d = fault_q;
      if (state_q == ST_IDLE && state_d == ST_OPEN_CHK)
         fault_d = FC_NONE;
      if (limit_fault_q)
         fault_d = FC_LIMIT;
      if (state_q == ST_OPEN_CHK && state_d == ST_LOCKOUT)
         fault_d = FC_PS_STUCK;
      if (state_q == ST_TRIAL && state_d == ST_LOCKOUT)
         fault_d = FC_NO_FLAME;
      if (state_q == ST_RUN && !flame_ok)
         fault_d = FC_FLAME_LOST;
   end

   // Output decode from the next state so outputs move with it; weak flame is decoded from the current state
   wire         nx_run   = state_d == ST_RUN;
   wire         nx_purge = state_d == ST_PREPURGE || state_d == ST_WARMUP ||
                           state_d == ST_TRIAL || state_d == ST_POSTPURGE;
   wire         ind_hi_d = nx_purge | (nx_run & stage2_req);
   wire         ind_lo_d = nx_run & !stage2_req;
   wire         hum_d    = nx_purge | nx_run;
   wire         ign_d    = state_d == ST_WARMUP || state_d == ST_TRIAL;
   wire         vmain_d  = state_d == ST_TRIAL || nx_run;
   wire         vhigh_d  = state_d == ST_TRIAL || (nx_run & stage2_req);
   wire         weak_d   = (state_q == ST_RUN) & flame_ok & flame_weak;
   wire         ltest_d  = (state_d == ST_IDLE) & !any_call;
   wire         lfault_d = limit_test_q ? !limit_return : limit_fault_q; // Held while untested
   wire         stg2_d   = hum_d ? stage2_req : stage2_q;

   // Sequencer registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         tmr_q   <= TMR_RST;
         fault_q <= FC_NONE;
      end
      else
      begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
         fault_q <= fault_d;
      end
   end

   // Registered burner outputs
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         {ind_hi_q, ind_lo_q, hum_q, ign_q} <= 4'h0;
         {vmain_q, vhigh_q, weak_q}         <= 3'h0;
         {limit_test_q, limit_fault_q}      <= 2'h0;
         stage2_q                           <= 1'b0;
      end
      else
      begin
         {ind_hi_q, ind_lo_q, hum_q, ign_q} <= {ind_hi_d, ind_lo_d, hum_d, ign_d};
         {vmain_q, vhigh_q, weak_q}         <= {vmain_d, vhigh_d, weak_d};
         {limit_test_q, limit_fault_q}      <= {ltest_d, lfault_d};
         stage2_q                           <= stg2_d;
      end
   end

   // Blower: delayed start after proof, off delay after the call ends
   always_comb
   begin
      blw_d = blw_q;
      unique case (blw_q)
         BL_OFF:
            if (state_q == ST_RUN)
               blw_d = BL_WAIT;
         BL_WAIT:
            if (state_q != ST_RUN)
               blw_d = BL_OFF;
            else if (bon_done)
               blw_d = BL_ON;
         BL_ON:
            if (state_q != ST_RUN)
               blw_d = BL_DELAY;
         BL_DELAY:
            if (state_q == ST_RUN)
               blw_d = BL_ON;
            else if (boff_done)
               blw_d = BL_OFF;
      endcase
   end

   // Blower timer restarts on each blower state change
   assign btmr_d = (blw_d != blw_q) ? TMR_RST : btmr_q + 32'h1;
   wire         blw_on_d = blw_d == BL_ON || blw_d == BL_DELAY;
   // Low fire speed is taken as half of the configured high-fire airflow
   wire [7:0]   duty = stage2_q ? airflow : {1'b0, airflow[7:1]};

   // Blower registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         blw_q    <= BL_OFF;
         btmr_q   <= TMR_RST;
         blw_on_q <= 1'b0;
      end
      else
      begin
         blw_q    <= blw_d;
         btmr_q   <= btmr_d;
         blw_on_q <= blw_on_d;
      end
   end

   // Variable-speed blower drive
   hsq_pwm u_pwm (
      .clk_sys (clk_sys),
      .rst     (rst),
      .en      (blw_on_q),
      .duty    (duty),
      .pwm     (blower_pwm)
   );

   // Output ports
   assign limit_test_out       = limit_test_q;
   assign inducer_high         = ind_hi_q;
   assign inducer_low          = ind_lo_q;
   assign humidifier_out       = hum_q;
   assign ignitor_out          = ign_q;
   assign valve_main           = vmain_q;
   assign valve_high_fire      = vhigh_q;
   assign blower_enable        = blw_on_q;
   assign blower_low_heat_tap  = blw_on_q & !stage2_q;
   assign blower_high_heat_tap = blw_on_q & stage2_q;
   assign air_cleaner_out      = blw_on_q;
   assign weak_flame           = weak_q;
   assign fault_code           = fault_q;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_call_gone;
      state_q == ST_RUN && !heat_req;
   endsequence

   limit_test_a: assert property (state_q == ST_IDLE && !any_call |=> limit_test_out)
      else $error("limit test not driven in standby");
   ps_stuck_a: assert property (state_q == ST_OPEN_CHK && heat_req && ps_any |=>
      state_q == ST_LOCKOUT && fault_code == FC_PS_STUCK && !inducer_high)
      else $error("stuck pressure switch not caught");
   prepurge_out_a: assert property (state_q == ST_PREPURGE |-> inducer_high && humidifier_out)
      else $error("pre-purge outputs wrong");
   ps_wait_a: assert property (state_q == ST_PREPURGE && heat_req && !ps_both |=>
      state_q == ST_PREPURGE && !ignitor_out)
      else $error("ignition before switches proven");
   warmup_len_a: assert property ($rose(valve_main) |-> $past(state_q) == ST_WARMUP &&
      $past(tmr_q) == P_WARMUP_CYC - 32'h1 && $past(ignitor_out))
      else $error("valve opened without full warm-up");
   high_fire_a: assert property ($rose(valve_main) |-> valve_high_fire)
      else $error("valve not opened at high fire");
   flame_tmo_a: assert property (state_q == ST_TRIAL && heat_req && !flame_ok && tmo_done |=>
      !valve_main ##0 !ignitor_out ##0 fault_code == FC_NO_FLAME)
      else $error("flame timeout not handled");
   flame_min_a: assert property (state_q == ST_RUN && !flame_ok |=> !valve_main)
      else $error("valve held with no flame");
   low_speed_a: assert property (state_q == ST_RUN && !stage2_req && heat_req && flame_ok |=>
      inducer_low && !inducer_high)
      else $error("inducer not at low speed");
   blower_start_a: assert property ($rose(blw_on_q) && $past(blw_q) == BL_WAIT |->
      $past(btmr_q) == P_BLOWER_ON_CYC - 32'h1)
      else $error("blower start delay wrong");
   air_clean_a: assert property (air_cleaner_out == (blw_q == BL_ON || blw_q == BL_DELAY))
      else $error("air cleaner not following blower");
   post_purge_a: assert property (s_call_gone |=> !valve_main && inducer_high && humidifier_out)
      else $error("post-purge not entered");
   ign_off_a: assert property (state_q == ST_RUN |-> !ignitor_out)
      else $error("ignitor left on after proof");

endmodule : hsq_sequencer

/* File: testbench/hsq_plant.sv */
// Purpose: Far-side model of the burner: pressure switches, flame sensor, limit string
// Assumes: Switches prove four cycles after the inducer starts, flame three after the valve
// Notes:   Limit return only echoes the test drive; the line has no pull-up

`timescale 1ns/10ps

module hsq_plant
   import hsq_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Board outputs seen by the plant
   input  wire logic       inducer_high,
   input  wire logic       inducer_low,
   input  wire logic       valve_main,
   input  wire logic       limit_test_out,
   // Fault knobs from the bench
   input  wire logic       ps_stuck,
   input  wire logic       limit_open,
   input  wire logic [7:0] flame_set,
   // Plant answers
   output logic            ps_low_closed,
   output logic            ps_high_closed,
   output logic            limit_return,
   output logic [7:0]      flame_ua_x10
);
   logic [2:0] air_q;
   logic [1:0] flm_q;

   // Air and flame build up slowly, so the board really has to wait for proof
   always_ff @(posedge clk_sys)
   begin
      air_q <= (rst || !(inducer_high || inducer_low)) ? 3'h0 : ((air_q == 3'h4) ? air_q : air_q + 3'h1);
      flm_q <= (rst || !valve_main) ? 2'h0 : ((flm_q == 2'h3) ? flm_q : flm_q + 2'h1);
   end

   // High-fire switch drops out as soon as the inducer slows, as a real one would
   assign ps_low_closed  = ps_stuck || (air_q == 3'h4);
   assign ps_high_closed = ps_stuck || ((air_q == 3'h4) && inducer_high);
   assign limit_return   = limit_test_out && !limit_open;
   assign flame_ua_x10   = (flm_q == 2'h3) ? flame_set : 8'h00;
endmodule : hsq_plant

/* File: testbench/hsq_sequencer_test.sv */
// Purpose: Self-checking bench for the heat sequencer
// Assumes: Shortened timers; the plant model answers for switches and flame
// Notes:   Counted intervals allow a cycle of slack where the start edge is loose

`timescale 1ns/10ps

module hsq_sequencer_test
   import hsq_pkg::*;
;
   localparam int WARM = 32'h14, BLON = 32'h1e, PURG = 32'h0f, FTMO = 32'h0a, OFF0 = 32'h6, OFF1 = 32'h9;
   localparam int I_IH = 4, I_IL = 3, I_IGN = 2, I_VM = 1, I_BE = 0;

   logic             clk_sys, rst, heat_stage1_call, heat_stage2_call, cool_call, fan_call, ps_stuck, limit_open;
   logic             ps_low_closed, ps_high_closed, limit_return, master_present, master_force_heat1, master_force_heat2;
   logic [7:0]       flame_ua_x10, jumper_airflow, master_airflow, flame_set;
   logic [1:0]       jumper_off_delay, master_off_delay;
   logic             limit_test_out, inducer_high, inducer_low, humidifier_out, ignitor_out, valve_main;
   logic             valve_high_fire, blower_enable, blower_pwm, blower_low_heat_tap, blower_high_heat_tap;
   logic             air_cleaner_out, weak_flame;
   logic [3:0]       fault_code;
   wire  logic [4:0] obs;
   int               miscompares, checks_done;

   // Outputs that the bounded wait can watch
   assign obs = {inducer_high, inducer_low, ignitor_out, valve_main, blower_enable};

   hsq_sequencer #(.P_WARMUP_CYC(WARM), .P_BLOWER_ON_CYC(BLON), .P_POSTPURGE_CYC(PURG), .P_FLAME_TMO_CYC(FTMO),
      .P_OFFDLY0_CYC(OFF0), .P_OFFDLY1_CYC(OFF1), .P_OFFDLY2_CYC(32'hc), .P_OFFDLY3_CYC(32'h12)) uut (
      .clk_sys, .rst, .heat_stage1_call, .heat_stage2_call, .cool_call, .fan_call, .ps_low_closed, .ps_high_closed,
      .limit_return, .flame_ua_x10, .jumper_airflow, .jumper_off_delay, .master_present, .master_force_heat1,
      .master_force_heat2, .master_airflow, .master_off_delay, .limit_test_out, .inducer_high, .inducer_low,
      .humidifier_out, .ignitor_out, .valve_main, .valve_high_fire, .blower_enable, .blower_pwm, .blower_low_heat_tap,
      .blower_high_heat_tap, .air_cleaner_out, .weak_flame, .fault_code);

   hsq_plant plant (.clk_sys, .rst, .inducer_high, .inducer_low, .valve_main, .limit_test_out, .ps_stuck,
      .limit_open, .flame_set, .ps_low_closed, .ps_high_closed, .limit_return, .flame_ua_x10);

   // 10 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Verdict, reached from the main sequence and from any wait that runs out
   task automatic tally_and_finish();
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // Value compare; case inequality so an unknown never matches
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Interval compare for counted cycles
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      checks_done++;
      if (got < lo || got > hi)
      begin
         miscompares++;
         $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   // Bounded wait for one output to reach a level; n gives the cycles taken
   task automatic wait_bit(input int idx, input logic lvl, input int lim, output int n);
      n = 0;
      while (obs[idx] !== lvl)
      begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > lim)
         begin
            miscompares++;
            $display("BAD wait on output %0d expected %b seen %b", idx, lvl, obs[idx]);
            tally_and_finish();
         end
      end
   endtask : wait_bit

   // Let k edges pass, then step clear of the edge
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : cyc

   // Thermostat calls change only at an edge
   task automatic drv(input logic a, input logic b);
      @(posedge clk_sys);
      heat_stage1_call <= a;
      heat_stage2_call <= b;
      #1;
   endtask : drv

   // High time of the blower speed signal over one 256-cycle period
   task automatic count_pwm(output int n);
      n = 0;
      repeat (256)
      begin
         @(posedge clk_sys);
         #1;
         n += (blower_pwm === 1'b1);
      end
   endtask : count_pwm

   // Standby limit test, fan call suspending it, open limit blocking a start
   task automatic t_standby();
      cyc(3);
      chk("limit drive", 1'b1, limit_test_out);  // Standby drive
      @(posedge clk_sys);
      fan_call <= 1'b1;
      cyc(3);
      chk("limit drive fan", 1'b0, limit_test_out);  // Off with a call
      @(posedge clk_sys);
      fan_call <= 1'b0;
      cool_call <= 1'b1;
      cyc(3);
      chk("limit drive cool", 1'b0, limit_test_out);  // Off
      @(posedge clk_sys);
      cool_call <= 1'b0;
      @(posedge clk_sys);
      limit_open <= 1'b1;
      cyc(4);
      chk("limit fault", FC_LIMIT, fault_code);  // Lost return
      drv(1'b1, 1'b0);
      cyc(6);
      chk("start in limit fault", 8'h00, {inducer_high, valve_main});  // No gas
      drv(1'b0, 1'b0);
      @(posedge clk_sys);
      limit_open <= 1'b0;
      cyc(5);
      chk("limit code kept", FC_LIMIT, fault_code);  // Latched till next start
   endtask : t_standby

   // First-stage cycle from call to the end of post-purge
   task automatic t_stage1();
      int         n;
      int         m;
      logic [7:0] fl [4];
      fl = '{8'h01, 8'h0e, 8'h0f, 8'h25};
      drv(1'b1, 1'b0);  // Stage one alone
      wait_bit(I_IH, 1'b1, 10, n);
      chk("humidifier", 1'b1, humidifier_out);  // With pre-purge
      chk("early ignitor", 1'b0, ignitor_out);  // Waits for proof
      chk("limit drive call", 1'b0, limit_test_out);  // Suspended
      chk("fault cleared", FC_NONE, fault_code);  // Cleared at start
      wait_bit(I_IGN, 1'b1, 20, n);
      chk("switches", 8'h03, {ps_low_closed, ps_high_closed});  // Both proven
      wait_bit(I_VM, 1'b1, 40, n);
      chk_rng("warm-up", WARM - 1, WARM + 1, n);  // Ignitor time
      chk("high fire", 1'b1, valve_high_fire);  // Opens high
      wait_bit(I_IL, 1'b1, 10, n);
      chk_rng("proof", 1, 6, n);  // Short window
      chk("run outputs", 8'h00, {inducer_high, ignitor_out, valve_high_fire});  // Low fire
      wait_bit(I_BE, 1'b1, 40, n);
      chk_rng("blower delay", BLON, BLON + 2, n);  // After proof
      chk("blower outputs", 8'h0b, {air_cleaner_out, blower_high_heat_tap, blower_low_heat_tap, blower_enable});
      count_pwm(n);
      chk_rng("low duty", 63, 65, n);  // Half airflow
      foreach (fl[i])
      begin
         @(posedge clk_sys);
         flame_set <= fl[i];
         cyc(5);
         chk("weak flame", fl[i] < FLAME_WEAK_X10, weak_flame);  // Amber below 1.5 uA
         chk("valve held", 1'b1, valve_main);  // Runs down to 0.1 uA
      end
      drv(1'b0, 1'b0);
      wait_bit(I_VM, 1'b0, 2, n);
      chk("purge", 8'h03, {inducer_high, humidifier_out});  // Gas off, purge on
      wait_bit(I_BE, 1'b0, 20, n);
      chk_rng("off delay", OFF1 - 1, OFF1 + 2, n);  // Jumper delay
      chk("cleaner off", 1'b0, air_cleaner_out);  // Follows blower
      wait_bit(I_IH, 1'b0, 20, m);
      chk_rng("post-purge", PURG - 1, PURG + 2, n + m);  // Purge length
      chk("humidifier off", 1'b0, humidifier_out);  // Released after purge
   endtask : t_stage1

   // Refused calls, then a master-forced second-stage cycle with soft settings
   task automatic t_master();
      int n;
      @(posedge clk_sys);
      master_force_heat1 <= 1'b1;
      master_force_heat2 <= 1'b1;
      heat_stage2_call   <= 1'b1;
      cyc(10);
      chk("ignored calls", 1'b0, inducer_high);  // Stage two alone, force without master
      @(posedge clk_sys);
      heat_stage2_call <= 1'b0;
      master_present   <= 1'b1;
      #1;
      wait_bit(I_BE, 1'b1, 90, n);
      chk("stage two run", 8'h1d,
          {inducer_high, valve_high_fire, blower_high_heat_tap, blower_low_heat_tap, blower_enable});
      count_pwm(n);
      chk_rng("high duty", 191, 193, n);  // Master airflow
      @(posedge clk_sys);
      master_force_heat1 <= 1'b0;
      master_force_heat2 <= 1'b0;
      #1;
      wait_bit(I_VM, 1'b0, 3, n);
      wait_bit(I_BE, 1'b0, 20, n);
      chk_rng("master delay", OFF0 - 1, OFF0 + 2, n);  // Soft setting wins
      wait_bit(I_IH, 1'b0, 20, n);
      @(posedge clk_sys);
      master_present <= 1'b0;
      #1;
   endtask : t_master

   // Pressure switch already closed at cycle start
   task automatic t_stuck();
      @(posedge clk_sys);
      ps_stuck <= 1'b1;
      drv(1'b1, 1'b0);
      cyc(6);
      chk("stuck code", FC_PS_STUCK, fault_code);  // Two flashes
      chk("stuck inducer", 1'b0, inducer_high);  // Cycle halted
      drv(1'b0, 1'b0);
      @(posedge clk_sys);
      ps_stuck <= 1'b0;
      cyc(3);
   endtask : t_stuck

   // No flame after the valve opens
   task automatic t_no_flame();
      int n;
      @(posedge clk_sys);
      flame_set <= 8'h00;
      drv(1'b1, 1'b0);
      wait_bit(I_VM, 1'b1, 40, n);
      wait_bit(I_VM, 1'b0, 14, n);
      chk_rng("flame timeout", FTMO - 1, FTMO + 2, n);  // Trial length
      cyc(2);
      chk("no-flame state", {FC_NO_FLAME, 4'h0}, {fault_code, 3'h0, ignitor_out});  // Lockout
      drv(1'b0, 1'b0);
      @(posedge clk_sys);
      flame_set <= 8'h25;
      cyc(3);
   endtask : t_no_flame

   // Flame lost while running
   task automatic t_flame_loss();
      int n;
      drv(1'b1, 1'b0);
      wait_bit(I_IL, 1'b1, 60, n);
      @(posedge clk_sys);
      flame_set <= 8'h00;
      #1;
      wait_bit(I_VM, 1'b0, 4, n);  // Gas shut below 0.1 uA
      drv(1'b0, 1'b0);
      cyc(2);
      chk("flame lost code", FC_FLAME_LOST, fault_code);  // Cycle stopped
      wait_bit(I_IH, 1'b0, 30, n);
      @(posedge clk_sys);
      flame_set <= 8'h25;
      cyc(2);
   endtask : t_flame_loss

   // Main sequence; fan and cool calls cover the suspend path
   initial
   begin
      rst = 1'b1;
      {heat_stage1_call, heat_stage2_call, cool_call, fan_call, ps_stuck, limit_open} = 6'h0;
      {master_present, master_force_heat1, master_force_heat2} = 3'h0;
      jumper_airflow   = 8'h80;
      master_airflow   = 8'hc0;
      flame_set        = 8'h25;
      jumper_off_delay = 2'h1;
      master_off_delay = 2'h0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_standby();
      t_stage1();
      t_master();
      t_stuck();
      t_no_flame();
      t_flame_loss();
      tally_and_finish();
   end
endmodule : hsq_sequencer_test
